// ===== logic/acssd_pkg.sv
// constants, types and opcode map of the ata command decoder
// Summary of operation
// - 40h/41h/42h decode as verify sectors
// - C8h/C9h/25h decode as dma read
// - 20h/21h/24h decode as pio read
// - 30h/31h/34h decode as pio write
// - CAh and 35h decode as dma write
// - F9h features 00h/01h, 37h max address
// - B1h features C0h/C1h/C2h configuration overlay
// - F8h and 27h read native max
// - factory master password 20h, lock off
// - master password set leaves lock unchanged
// - user password locks at next power-on
// - locked device refuses media access commands
// - high level: master password unlocks
// - maximum level: master only via erase
// - smart features D0h-D6h, D8h-DBh mapped
// - D0h: busy, save, drq, unbusy, irq
// - D1h: fetch thresholds, await 512 bytes
// - command write starts execution at once
// - status read clears pending interrupt
// - abort flag on bad parameter
package acssd_pkg;
  // byte offsets of the wishbone registers
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_FEAT   = 8'h08;
  localparam logic [7:0] OFS_ERROR  = 8'h0C;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] OFS_PWD    = 8'h14;
  localparam logic [7:0] OFS_SEC    = 8'h18;
  localparam logic [7:0] OFS_LIVE   = 8'h1C;
  localparam logic [7:0] OFS_THR    = 8'h20;
  // status and error bit positions
  localparam int ST_BSY     = 7;
  localparam int ST_READY   = 6;
  localparam int ST_DRQ     = 3;
  localparam int ST_ERR     = 0;
  localparam int ER_ABORTED = 2;
  // feature bits of the security set-password command
  localparam int FT_MASTER = 0;
  localparam int FT_MAXLVL = 1;
  // factory master password, ascii blanks
  localparam logic [31:0] MASTER_RST = 32'h20202020;
  // block transfer: 512 bytes as 32-bit words
  localparam int BLK_BYTES = 512;
  localparam int BLK_WORDS = BLK_BYTES / 4;
  localparam logic [6:0] LAST_WORD = 7'(BLK_WORDS - 1);
  // decoded command classes
  typedef enum logic [3:0] {
    CL_BAD    = 4'h0, CL_MEDIA  = 4'h1, CL_OK     = 4'h2,
    CL_RDATTR = 4'h3, CL_RDTHR  = 4'h4, CL_SAVE   = 4'h5,
    CL_SETPW  = 4'h6, CL_UNLOCK = 4'h7, CL_ERASE  = 4'h8,
    CL_DISPW  = 4'h9
  } acssd_cls_t;
  // command engine states
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_EXEC = 2'h1, S_SAVE = 2'h2, S_DRQ = 2'h3
  } acssd_state_t;
  // wishbone request from the master
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } acssd_wb_req_t;
  // persistent security state
  typedef struct packed {
    logic locked;
    logic user_set;
    logic max_lvl;
  } acssd_sec_t;
endpackage

// ===== logic/acssd_decode.sv
// opcode and features decoder of the command engine
`timescale 1ns/1ps
module acssd_decode (
  input  wire logic [7:0]          opcode_i,
  input  wire logic [7:0]          feat_i,
  output acssd_pkg::acssd_cls_t    cls_o
);
  // pure lookup; unknown opcode or subcode falls to abort
  always_comb
  begin
    cls_o = acssd_pkg::CL_BAD;
    case (opcode_i)
      8'h40, 8'h41, 8'h42: cls_o = acssd_pkg::CL_MEDIA;
      8'hC8, 8'hC9, 8'h25: cls_o = acssd_pkg::CL_MEDIA;
      8'h20, 8'h21, 8'h24: cls_o = acssd_pkg::CL_MEDIA;
      8'h30, 8'h31, 8'h34: cls_o = acssd_pkg::CL_MEDIA;
      8'hCA, 8'h35:        cls_o = acssd_pkg::CL_MEDIA;
      8'h37, 8'hF8, 8'h27: cls_o = acssd_pkg::CL_OK;
      8'hF9:
      begin
        // max address family picked by features
        if (feat_i == 8'h00 || feat_i == 8'h01)
          cls_o = acssd_pkg::CL_OK;
      end
      8'hB1:
      begin
        // configuration overlay family
        if (feat_i >= 8'hC0 && feat_i <= 8'hC2)
          cls_o = acssd_pkg::CL_OK;
      end
      8'hB0:
      begin
        // smart subcommand comes from features
        case (feat_i)
          8'hD0: cls_o = acssd_pkg::CL_RDATTR;
          8'hD1: cls_o = acssd_pkg::CL_RDTHR;
          8'hD3: cls_o = acssd_pkg::CL_SAVE;
          8'hD2, 8'hD4, 8'hD5, 8'hD6,
          8'hD8, 8'hD9, 8'hDA, 8'hDB:
            cls_o = acssd_pkg::CL_OK;
          default: cls_o = acssd_pkg::CL_BAD;
        endcase
      end
      8'hF1:   cls_o = acssd_pkg::CL_SETPW;
      8'hF2:   cls_o = acssd_pkg::CL_UNLOCK;
      8'hF4:   cls_o = acssd_pkg::CL_ERASE;
      8'hF6:   cls_o = acssd_pkg::CL_DISPW;
      default: cls_o = acssd_pkg::CL_BAD;
    endcase
  end
endmodule

// ===== logic/acssd_secure.sv
// password lock state of the security feature set
`timescale 1ns/1ps
module acssd_secure (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                go_i,
  input  acssd_pkg::acssd_cls_t    op_i,
  input  wire logic                master_i,
  input  wire logic                maxlvl_i,
  input  wire logic [31:0]         pwd_i,
  input  wire logic                pwr_on_i,
  output acssd_pkg::acssd_sec_t    sec_o,
  output logic                     ok_o,
  output logic                     erase_o
);
  acssd_pkg::acssd_sec_t sec_q, sec_d;   // persistent flags
  logic [31:0] mpw_q, mpw_d;             // master password
  logic [31:0] upw_q, upw_d;             // user password
  logic        ers_q, ers_d;             // erase pulse
  logic        u_hit;                    // user password match
  logic        m_hit;                    // master password match

  assign u_hit   = sec_q.user_set && (pwd_i == upw_q);
  assign m_hit   = (pwd_i == mpw_q);
  assign sec_o   = sec_q;
  assign erase_o = ers_q;

  // verdict on the requested operation
  always_comb
  begin
    case (op_i)
      acssd_pkg::CL_SETPW:  ok_o = !sec_q.locked;
      // master only helps at high level
      acssd_pkg::CL_UNLOCK: ok_o = u_hit || (m_hit && !sec_q.max_lvl);
      acssd_pkg::CL_ERASE:  ok_o = u_hit || m_hit;
      acssd_pkg::CL_DISPW:  ok_o = u_hit && !sec_q.locked;
      default:              ok_o = 1'b1;
    endcase
  end

  // next state of passwords and lock
  always_comb
  begin
    sec_d = sec_q;
    mpw_d = mpw_q;
    upw_d = upw_q;
    ers_d = 1'b0;
    // power-on re-arms the lock from the kept flag
    if (pwr_on_i)
      sec_d.locked = sec_q.user_set;
    if (go_i && ok_o)
    begin
      case (op_i)
        acssd_pkg::CL_SETPW:
        begin
          if (master_i)
            mpw_d = pwd_i; // lock untouched
          else
          begin
            upw_d = pwd_i;
            sec_d.user_set = 1'b1; // locks only at power-on
            sec_d.max_lvl  = maxlvl_i;
          end
        end
        acssd_pkg::CL_UNLOCK: sec_d.locked = 1'b0;
        acssd_pkg::CL_ERASE:
        begin
          // wipe user data, drop user password, unlock
          sec_d = '0;
          ers_d = 1'b1;
        end
        acssd_pkg::CL_DISPW: sec_d.user_set = 1'b0;
        default: sec_d = sec_q;
      endcase
    end
  end

  // rst_i stands for manufacture; pwr_on_i for power cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sec_q <= '0;                     // lock disabled
      mpw_q <= acssd_pkg::MASTER_RST;
      upw_q <= 32'h00000000;
      ers_q <= 1'b0;
    end
    else if (ce_i)
    begin
      sec_q <= sec_d;
      mpw_q <= mpw_d;
      upw_q <= upw_d;
      ers_q <= ers_d;
    end
  end

  // lock must follow the user flag after power-on
  chk_pwr_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && pwr_on_i && !go_i && sec_q.user_set) |=> sec_q.locked)
    else $error("power-on did not lock");
  // maximum level: a bare master unlock leaves the lock shut
  chk_max_unlock: assert property (@(posedge clk_i)
    disable iff (rst_i)
    (ce_i && go_i && op_i == acssd_pkg::CL_UNLOCK && sec_q.max_lvl &&
     sec_q.locked && !u_hit) |=> sec_q.locked)
    else $error("master unlock at maximum level");
endmodule

// ===== logic/acssd_top.sv
// command engine with wishbone registers, smart and lock
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module acssd_top (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  acssd_pkg::acssd_wb_req_t wb_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     intrq_o,
  output logic                     media_go_o,
  output logic [7:0]               media_op_o,
  output logic                     erase_o
);
  acssd_pkg::acssd_state_t state_q, state_d; // engine state
  acssd_pkg::acssd_cls_t   cls;              // decoded command
  acssd_pkg::acssd_sec_t   sec;              // lock flags
  logic [7:0]  cmd_q, cmd_d;       // latched opcode
  logic [7:0]  feat_q, feat_d;     // features register
  logic [31:0] pwd_q, pwd_d;       // password staging word
  logic        abort_q, abort_d;   // aborted_command_flag
  logic        err_q, err_d;       // status error bit
  logic        irq_q, irq_d;       // pending interrupt
  logic        ack_q, ack_d;       // bus acknowledge
  logic [31:0] dat_q, dat_d;       // registered read data
  logic [6:0]  xfer_q, xfer_d;     // words sent in block
  logic        thr_q, thr_d;       // block source: thresholds
  logic [6:0]  ldp_q, ldp_d;       // software load pointer
  logic        mgo_q, mgo_d;       // media dispatch pulse
  logic [31:0] live_q [acssd_pkg::BLK_WORDS]; // live attributes
  logic [31:0] live_d [acssd_pkg::BLK_WORDS];
  logic [31:0] thrs_q [acssd_pkg::BLK_WORDS]; // thresholds
  logic [31:0] thrs_d [acssd_pkg::BLK_WORDS];
  logic [31:0] svd_q  [acssd_pkg::BLK_WORDS]; // saved attributes
  logic [31:0] svd_d  [acssd_pkg::BLK_WORDS];
  logic        hit;                // fresh bus request
  logic        wr;                 // bus write this cycle
  logic        rd;                 // bus read this cycle
  logic        busy;               // busy bit of status
  logic        drq;                // data request bit
  logic [7:0]  status;             // status byte
  logic        st_rd;              // status read, irq ack
  logic        dat_rd;             // block word taken
  logic        irq_set;            // interrupt raised
  logic        sec_go;             // run security op
  logic        sec_ok;             // security op allowed
  logic        pwr_on;             // power-on event
  logic [31:0] rdata;              // read mux

  // one-cycle answer; ack drops the cycle after it is given
  assign hit  = wb_i.cyc && wb_i.stb && !ack_q;
  assign wr   = hit && wb_i.we;
  assign rd   = hit && !wb_i.we;
  assign busy = (state_q == acssd_pkg::S_EXEC) ||
                (state_q == acssd_pkg::S_SAVE);
  assign drq  = (state_q == acssd_pkg::S_DRQ);

  // status byte; ready is simply the inverse of busy here
  always_comb
  begin
    status = 8'h00;
    status[acssd_pkg::ST_BSY]   = busy;
    status[acssd_pkg::ST_READY] = !busy;
    status[acssd_pkg::ST_DRQ]   = drq;
    status[acssd_pkg::ST_ERR]   = err_q;
  end
  // any read while busy returns status, so it also acks
  assign st_rd  = rd && (busy || wb_i.adr == acssd_pkg::OFS_STATUS);
  assign dat_rd = rd && drq && !busy &&
                  wb_i.adr == acssd_pkg::OFS_DATA;
  assign pwr_on = wr && !busy && wb_i.sel[0] && wb_i.dat[0] &&
                  wb_i.adr == acssd_pkg::OFS_SEC;
  assign sec_go = (state_q == acssd_pkg::S_EXEC);

  assign wb_dat_o   = dat_q;
  assign wb_ack_o   = ack_q;
  assign intrq_o    = irq_q;
  assign media_go_o = mgo_q;
  assign media_op_o = cmd_q;

  acssd_decode u_decode (
    .opcode_i (cmd_q),
    .feat_i   (feat_q),
    .cls_o    (cls)
  );

  acssd_secure u_secure (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .go_i     (sec_go),
    .op_i     (cls),
    .master_i (feat_q[acssd_pkg::FT_MASTER]),
    .maxlvl_i (feat_q[acssd_pkg::FT_MAXLVL]),
    .pwd_i    (pwd_q),
    .pwr_on_i (pwr_on),
    .sec_o    (sec),
    .ok_o     (sec_ok),
    .erase_o  (erase_o)
  );

  // read mux; any read while busy gets status, else unmapped offsets read zero
  always_comb
  begin
    rdata = 32'h00000000;
    if (busy)
      rdata = {24'h000000, status};
    else
    begin
      case (wb_i.adr)
        acssd_pkg::OFS_STATUS: rdata = {24'h000000, status};
        acssd_pkg::OFS_FEAT:   rdata = {24'h000000, feat_q};
        acssd_pkg::OFS_ERROR:  rdata[acssd_pkg::ER_ABORTED] = abort_q;
        acssd_pkg::OFS_DATA:
          rdata = !drq ? 32'h00000000 :
                  thr_q ? thrs_q[xfer_q] : svd_q[xfer_q];
        acssd_pkg::OFS_SEC:    rdata = {29'h0, sec};
        default:               rdata = 32'h00000000;
      endcase
    end
  end

  // bus side: ack, read data, parameter registers, tables
  always_comb
  begin
    ack_d  = hit;
    dat_d  = rd ? rdata : dat_q;
    feat_d = feat_q;
    pwd_d  = pwd_q;
    ldp_d  = ldp_q;
    live_d = live_q;
    thrs_d = thrs_q;
    // parameter writes are shut out while busy
    if (wr && !busy)
    begin
      case (wb_i.adr)
        acssd_pkg::OFS_FEAT:
          if (wb_i.sel[0])
            feat_d = wb_i.dat[7:0]; // host loads this first
        acssd_pkg::OFS_PWD:
          for (int b = 0; b < 4; b++)
            if (wb_i.sel[b])
              pwd_d[8*b +: 8] = wb_i.dat[8*b +: 8];
        acssd_pkg::OFS_LIVE:
        begin
          live_d[ldp_q] = wb_i.dat;
          ldp_d = ldp_q + 7'd1;
        end
        acssd_pkg::OFS_THR:
        begin
          thrs_d[ldp_q] = wb_i.dat;
          ldp_d = ldp_q + 7'd1;
        end
        default: ldp_d = ldp_q;
      endcase
    end
  end

  // command engine
  always_comb
  begin
    state_d = state_q;
    cmd_d   = cmd_q;
    abort_d = abort_q;
    err_d   = err_q;
    xfer_d  = xfer_q;
    thr_d   = thr_q;
    svd_d   = svd_q;
    mgo_d   = 1'b0;
    irq_set = 1'b0;
    case (state_q)
      acssd_pkg::S_IDLE:
      begin
        // writing the opcode starts the command
        if (wr && wb_i.sel[0] && wb_i.adr == acssd_pkg::OFS_CMD)
        begin
          cmd_d   = wb_i.dat[7:0];
          abort_d = 1'b0;
          err_d   = 1'b0;
          state_d = acssd_pkg::S_EXEC;
        end
      end
      acssd_pkg::S_EXEC:
      begin
        irq_set = 1'b1;
        state_d = acssd_pkg::S_IDLE;
        case (cls)
          acssd_pkg::CL_MEDIA:
          begin
            if (sec.locked)
            begin
              abort_d = 1'b1;
              err_d  = 1'b1;
            end
            else
              mgo_d = 1'b1; // hand to the media back end
          end
          acssd_pkg::CL_RDATTR, acssd_pkg::CL_SAVE:
          begin
            // stay busy one more cycle to store values
            irq_set = 1'b0;
            state_d = acssd_pkg::S_SAVE;
          end
          acssd_pkg::CL_RDTHR:
          begin
            thr_d   = 1'b1; // fetch thresholds
            xfer_d  = 7'd0;
            state_d = acssd_pkg::S_DRQ;
          end
          acssd_pkg::CL_SETPW, acssd_pkg::CL_UNLOCK,
          acssd_pkg::CL_ERASE, acssd_pkg::CL_DISPW:
          begin
            if (!sec_ok)
            begin
              abort_d = 1'b1;
              err_d  = 1'b1;
            end
          end
          acssd_pkg::CL_BAD:
          begin
            abort_d = 1'b1;
            err_d  = 1'b1;
          end
          default: abort_d = abort_q;
        endcase
      end
      acssd_pkg::S_SAVE:
      begin
        // snapshot live table into the saved sector
        svd_d   = live_q;
        irq_set = 1'b1;
        state_d = acssd_pkg::S_IDLE;
        if (cls == acssd_pkg::CL_RDATTR)
        begin
          // drq up, busy down, irq up together
          thr_d   = 1'b0;
          xfer_d  = 7'd0;
          state_d = acssd_pkg::S_DRQ;
        end
      end
      acssd_pkg::S_DRQ:
      begin
        // block ends after the last 32-bit word
        if (dat_rd)
        begin
          xfer_d = xfer_q + 7'd1;
          if (xfer_q == acssd_pkg::LAST_WORD)
            state_d = acssd_pkg::S_IDLE;
        end
      end
      default: state_d = acssd_pkg::S_IDLE;
    endcase
  end

  // set wins over the acknowledge of a status read
  always_comb
  begin
    irq_d = irq_q;
    if (st_rd)
      irq_d = 1'b0;
    if (irq_set)
      irq_d = 1'b1;
  end

  // register stage; tables hold no reset-time user data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= acssd_pkg::S_IDLE;
      cmd_q   <= 8'h00;
      feat_q  <= 8'h00;
      pwd_q   <= 32'h00000000;
      abort_q <= 1'b0;
      err_q   <= 1'b0;
      irq_q   <= 1'b0;
      ack_q   <= 1'b0;
      dat_q   <= 32'h00000000;
      xfer_q  <= 7'd0;
      thr_q   <= 1'b0;
      ldp_q   <= 7'd0;
      mgo_q   <= 1'b0;
      for (int i = 0; i < acssd_pkg::BLK_WORDS; i++)
      begin
        live_q[i] <= 32'h00000000;
        thrs_q[i] <= 32'h00000000;
        svd_q[i]  <= 32'h00000000;
      end
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      feat_q  <= feat_d;
      pwd_q   <= pwd_d;
      abort_q <= abort_d;
      err_q   <= err_d;
      irq_q   <= irq_d;
      ack_q   <= ack_d;
      dat_q   <= dat_d;
      xfer_q  <= xfer_d;
      thr_q   <= thr_d;
      ldp_q   <= ldp_d;
      mgo_q   <= mgo_d;
      live_q  <= live_d;
      thrs_q  <= thrs_d;
      svd_q   <= svd_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_cmd_start: assert property (
    (ce_i && state_q == acssd_pkg::S_IDLE && wr && wb_i.sel[0] &&
     wb_i.adr == acssd_pkg::OFS_CMD) |=> busy)
    else $error("command write did not start");
  chk_lock_refuse: assert property (
    (ce_i && sec_go && cls == acssd_pkg::CL_MEDIA && sec.locked)
      |=> abort_q && err_q && irq_q && !mgo_q)
    else $error("locked media command not refused");
  chk_media_go: assert property (
    (ce_i && sec_go && cls == acssd_pkg::CL_MEDIA && !sec.locked)
      |=> mgo_q && !abort_q)
    else $error("media command not dispatched");
  chk_attr_order: assert property (
    (ce_i && sec_go && cls == acssd_pkg::CL_RDATTR)
      |=> (busy && !drq) and (ce_i |=> drq && !busy && irq_q))
    else $error("attribute read sequence wrong");
  chk_thr_drq: assert property (
    (ce_i && sec_go && cls == acssd_pkg::CL_RDTHR) |=> drq && thr_q)
    else $error("threshold read did not raise drq");
  chk_bad_abort: assert property (
    (ce_i && sec_go && cls == acssd_pkg::CL_BAD)
      |=> abort_q && err_q && irq_q)
    else $error("invalid command not aborted");
  chk_irq_ack: assert property (
    (ce_i && st_rd && !irq_set) |=> !irq_q)
    else $error("status read left interrupt pending");
  chk_block_len: assert property (
    (ce_i && dat_rd && xfer_q != acssd_pkg::LAST_WORD) |=> drq)
    else $error("block ended early");
  chk_block_end: assert property (
    (ce_i && dat_rd && xfer_q == acssd_pkg::LAST_WORD) |=> !drq)
    else $error("block did not end after 512 bytes");
  cov_attr_done: cover property (dat_rd && !thr_q &&
    xfer_q == acssd_pkg::LAST_WORD);
  cov_lock_ref: cover property (sec_go && sec.locked &&
    cls == acssd_pkg::CL_MEDIA);
  cov_unlock: cover property (sec_go && sec_ok &&
    cls == acssd_pkg::CL_UNLOCK);
endmodule

// ===== dv/acssd_host.sv
// host model: wishbone master issuing shadow register accesses
`timescale 1ns/1ps
module acssd_host (
  input  wire logic                clk_i,
  input  wire logic                ack_i,
  input  wire logic [31:0]         dat_i,
  input  wire logic                intrq_i,
  output acssd_pkg::acssd_wb_req_t wb_o
);
  initial wb_o = '0;
  // one classic cycle held until ack; on release adr, dat and we show inverted values, sel, cyc and stb drop to zero
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    wb_o <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
    @(posedge clk_i);
    while (ack_i !== 1'b1)
      @(posedge clk_i);
    q = dat_i;
    wb_o <= '{adr: ~a, dat: ~d, sel: 4'h0, we: ~w, cyc: 1'b0, stb: 1'b0};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h00000000, q);
  endtask
  // features before opcode; wait for interrupt, then ack it by status read
  task automatic cmd(input logic [7:0] op, input logic [7:0] ft,
    output logic [31:0] st, output logic irq);
    int n;
    wr(acssd_pkg::OFS_FEAT, {24'h000000, ft});
    wr(acssd_pkg::OFS_CMD, {24'h000000, op});
    n = 0;
    while (intrq_i !== 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    irq = intrq_i;
    rd(acssd_pkg::OFS_STATUS, st);
  endtask
  // a whole 512-byte block as 128 words
  task automatic blk(output logic [31:0] w [128]);
    for (int i = 0; i < 128; i++)
      rd(acssd_pkg::OFS_DATA, w[i]);
  endtask
endmodule

// ===== dv/ata_command_security_smart_decoder_bench.sv
// self-checking bench of the command decoder driven by the host model
`timescale 1ns/1ps
module ata_command_security_smart_decoder_bench;
  logic                     clk_i = 1'b0;   // 25 mhz
  logic                     rst_i = 1'b1;   // sync reset
  acssd_pkg::acssd_wb_req_t wb;             // host requests
  logic [31:0]              wb_dat;
  logic                     wb_ack;
  logic                     intrq;
  logic                     media_go;
  logic [7:0]               media_op;
  logic                     erase;
  int                       miscompares = 0;
  int                       n_checks = 0;
  int                       n_go = 0;       // media dispatch pulses
  int                       n_er = 0;       // erase pulses
  int                       cyc_n = 0;      // hang guard
  int                       g;
  logic [31:0]              st;
  logic [31:0]              q;
  logic                     irq;
  logic [31:0]              w [128];
  logic [7:0]               mops [14] = '{8'h40, 8'h41, 8'h42, 8'hC8,
    8'hC9, 8'h25, 8'h20, 8'h21, 8'h24, 8'h30, 8'h31, 8'h34, 8'hCA, 8'h35};
  // opcode, features, abort expected
  logic [16:0]              oth [19] = '{{16'hF900, 1'b0},
    {16'hF901, 1'b0}, {16'hF904, 1'b1}, {16'h3700, 1'b0},
    {16'hF800, 1'b0}, {16'h2700, 1'b0}, {16'hB1C0, 1'b0},
    {16'hB1C1, 1'b0}, {16'hB1C2, 1'b0}, {16'hB0D2, 1'b0},
    {16'hB0D3, 1'b0}, {16'hB0D4, 1'b0}, {16'hB0D5, 1'b0},
    {16'hB0D6, 1'b0}, {16'hB0D8, 1'b0}, {16'hB0D9, 1'b0},
    {16'hB0DA, 1'b0}, {16'hB0DB, 1'b0}, {16'h0000, 1'b1}};
  always #20 clk_i = ~clk_i;
  acssd_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .intrq_o(intrq),
    .media_go_o(media_go), .media_op_o(media_op), .erase_o(erase));
  acssd_host i_host (.clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_dat),
    .intrq_i(intrq), .wb_o(wb));
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // pulses last one cycle, so count them at every edge
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (media_go === 1'b1)
      n_go++;
    if (erase === 1'b1)
      n_er++;
    if (cyc_n == 20000)
    begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic sec_is(input logic [2:0] exp);
    i_host.rd(acssd_pkg::OFS_SEC, q);
    check(q, {29'h00000000, exp});
  endtask
  // err bit, abort flag and interrupt of the last command
  task automatic res_is(input logic ab);
    i_host.rd(acssd_pkg::OFS_ERROR, q);
    check({29'h0, irq, st[0], q[2]}, {29'h0, 1'b1, ab, ab});
  endtask
  initial
  begin
    do_reset();
    sec_is(3'b000);
    i_host.rd(8'h3C, q);
    check(q, 32'h00000000);
    i_host.wr(acssd_pkg::OFS_PWD, 32'h12345678);
    i_host.cmd(8'hF1, 8'h01, st, irq);
    i_host.wr(acssd_pkg::OFS_SEC, 32'h00000001);
    sec_is(3'b000);
    i_host.wr(acssd_pkg::OFS_PWD, 32'hCAFE0001);
    i_host.cmd(8'hF1, 8'h00, st, irq);
    sec_is(3'b010);
    i_host.wr(acssd_pkg::OFS_SEC, 32'h00000001);
    sec_is(3'b110);
    g = n_go;
    i_host.cmd(8'h20, 8'h00, st, irq);
    res_is(1'b1);
    check(n_go, g);
    i_host.wr(acssd_pkg::OFS_PWD, 32'h12345678);
    i_host.cmd(8'hF2, 8'h01, st, irq);
    sec_is(3'b010);
    foreach (mops[i])
    begin
      g = n_go;
      i_host.cmd(mops[i], 8'h00, st, irq);
      res_is(1'b0);
      check(n_go - g, 1);
      check({24'h000000, media_op}, {24'h000000, mops[i]});
    end
    foreach (oth[i])
    begin
      g = n_go;
      i_host.cmd(oth[i][16:9], oth[i][8:1], st, irq);
      res_is(oth[i][0]);
      check(n_go, g);
    end
    // maximum level: master opens only through erase
    i_host.wr(acssd_pkg::OFS_PWD, 32'hCAFE0002);
    i_host.cmd(8'hF1, 8'h02, st, irq);
    i_host.wr(acssd_pkg::OFS_SEC, 32'h00000001);
    sec_is(3'b111);
    i_host.wr(acssd_pkg::OFS_PWD, 32'h12345678);
    i_host.cmd(8'hF2, 8'h01, st, irq);
    res_is(1'b1);
    g = n_er;
    i_host.cmd(8'hF4, 8'h01, st, irq);
    check(n_er - g, 1);
    sec_is(3'b000);
    // second reset restores the factory master password
    do_reset();
    i_host.wr(acssd_pkg::OFS_PWD, 32'hCAFE0003);
    i_host.cmd(8'hF1, 8'h00, st, irq);
    i_host.wr(acssd_pkg::OFS_SEC, 32'h00000001);
    i_host.wr(acssd_pkg::OFS_PWD, 32'h20202020);
    i_host.cmd(8'hF2, 8'h01, st, irq);
    sec_is(3'b010);
    for (int i = 0; i < 128; i++)
      i_host.wr(acssd_pkg::OFS_LIVE, 32'hA0000000 | i);
    for (int i = 0; i < 128; i++)
      i_host.wr(acssd_pkg::OFS_THR, 32'h50000000 | i);
    for (int k = 0; k < 2; k++)
    begin
      i_host.cmd(8'hB0, 8'hD0 | 8'(k), st, irq);
      check({intrq, irq, st[7:0] & 8'h89}, 10'h108);
      i_host.blk(w);
      foreach (w[i])
        check(w[i], (k == 0 ? 32'hA0000000 : 32'h50000000) | i);
      i_host.rd(acssd_pkg::OFS_STATUS, st);
      check(st & 32'h00000089, 32'h00000000);
    end
    // disable password: a wrong word is refused, the right one clears
    i_host.wr(acssd_pkg::OFS_PWD, 32'h00000000);
    i_host.cmd(8'hF6, 8'h00, st, irq);
    res_is(1'b1);
    i_host.wr(acssd_pkg::OFS_PWD, 32'hCAFE0003);
    i_host.cmd(8'hF6, 8'h00, st, irq);
    sec_is(3'b000);
    i_host.wr(acssd_pkg::OFS_SEC, 32'h00000001);
    sec_is(3'b000);
    final_report();
  end
endmodule
